/* rtl/cas_pkg.sv */
// package: register map, reset values, timing and carrier types for the channel alarm block
package cas_pkg;

    // ------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [10:0] CAS_IDX_ERROR_INTERRUPT_MASK = 11'h7dd;
    localparam logic [10:0] CAS_IDX_ALARM_STATUS_A = 11'h7de;
    localparam logic [10:0] CAS_IDX_ALARM_STATUS_B = 11'h7df;
    localparam logic [10:0] CAS_IDX_STATUS_A_MASK = 11'h7e0;
    localparam logic [10:0] CAS_IDX_STATUS_B_MASK = 11'h7e1;
    localparam logic [10:0] CAS_IDX_STATUS_A_EDGE = 11'h7e2;
    localparam logic [10:0] CAS_IDX_STATUS_B_EDGE = 11'h7e3;
    localparam logic [10:0] CAS_IDX_STATUS_A_STICKY = 11'h7e4;
    localparam logic [10:0] CAS_IDX_STATUS_B_STICKY = 11'h7e5;
    localparam logic [10:0] CAS_IDX_ERROR_STICKY = 11'h7e6;

    // ------------------------------------------------------------------
    // implemented bits and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] CAS_ERR_BITS = 8'h3f;
    localparam logic [7:0] CAS_STAT_A_BITS = 8'h9f;
    localparam logic [7:0] CAS_STAT_B_BITS = 8'he3;
    localparam logic [7:0] CAS_ERR_MASK_RST = 8'h3f;
    localparam logic [7:0] CAS_STAT_A_MASK_RST = 8'h9f;
    localparam logic [7:0] CAS_STAT_B_MASK_RST = 8'he3;
    localparam logic [7:0] CAS_ZERO8_RST = 8'h00;
    localparam logic [31:0] CAS_ZERO32_RST = 32'h0000_0000;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CAS_B_ACTIVATE_POS = 1;
    localparam int CAS_B_DEACTIVATE_POS = 0;

    // ------------------------------------------------------------------
    // timing: clock rate and qualifying times
    // ------------------------------------------------------------------
    localparam longint unsigned CAS_CLK_KHZ = 250000;
    localparam longint unsigned CAS_SHORT_QUAL_MS = 40;
    // 5.1 s held in milliseconds
    localparam longint unsigned CAS_LONG_QUAL_MS = 5100;
    localparam longint unsigned CAS_SHORT_QUAL_CYC = CAS_SHORT_QUAL_MS * CAS_CLK_KHZ;
    localparam longint unsigned CAS_LONG_QUAL_CYC = CAS_LONG_QUAL_MS * CAS_CLK_KHZ;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CAS_BUS_IDLE = 2'b01,
        CAS_BUS_ACK = 2'b10
    } cas_bus_st_t;

    // live detector levels
    typedef struct packed {
        logic auto_loopback_state;
        logic driver_overcurrent_state;
        logic tx_clock_missing_state;
        logic tx_signal_loss_state;
        logic sys_signal_loss_state;
        logic line_signal_loss_state;
        logic sys_alarm_indication_state;
        logic line_alarm_indication_state;
        logic pattern_sync_state;
        logic inband_activate_detect;
        logic inband_deactivate_detect;
    } cas_alarm_t;

    // one-cycle error event pulses, packed in error mask bit order 5..0
    typedef struct packed {
        logic sys_bipolar_violation;
        logic line_bipolar_violation;
        logic sys_excess_zeros;
        logic line_excess_zeros;
        logic pattern_error;
        logic error_counter_overflow;
    } cas_error_t;

    typedef struct packed {
        cas_bus_st_t bus_st;
        logic waitreq;
        logic [31:0] rdata;
        logic irq;
        logic [7:0] err_mask;
        logic [7:0] mask_a;
        logic [7:0] mask_b;
        logic [7:0] edge_a;
        logic [7:0] edge_b;
        logic [7:0] sticky_a;
        logic [7:0] sticky_b;
        logic [7:0] sticky_err;
        logic [7:0] stat_a;
        logic [7:0] stat_b;
        logic [31:0] act_cnt;
        logic [31:0] deact_cnt;
    } cas_state_t;

endpackage

/* rtl/cas_channel_alarm.sv */
// module: per-channel alarm status, interrupt masks and sticky interrupt logic
`timescale 1ns/1ps

// How it works
// - implemented mask bits reset to 1 (masked); writing 0 enables the interrupt.
// - error mask bit 5 gates the system-side bipolar violation interrupt.
// - error mask bit 4 gates the line-side bipolar violation interrupt.
// - error mask bit 3 gates the system-side excess zeros interrupt.
// - error mask bit 2 gates the line-side excess zeros interrupt.
// - error mask bit 1 gates the test pattern error interrupt.
// - status A bit 7 shows automatic loopback state, zero after reset.
// - status A bit 4 shows line driver over-current fault, zero after reset.
// - status A bit 3 shows transmit clock missing.
// - status A bit 2 shows transmit-side loss of signal.
// - status A bit 1 shows system-side loss of signal.
// - status A bit 0 shows line-side loss of signal.
// - status B bit 7 shows system-side alarm indication, zero after reset.
// - status B bit 6 shows line-side alarm indication, zero after reset.
// - status B bit 5 shows test pattern sync, zero when out of sync.
// - status B bit 1 sets after activate code qualifies; over 5.1 s with auto loopback.
// - status B bit 0 sets after deactivate code over 40 ms, T1/J1, auto off.
// - status sticky bits set on rising edge, or any edge when edge-select is 1; error sticky bits set on each event cycle.
// - writing 1 clears a sticky bit, writing 0 leaves it alone.
// - any set sticky bit with mask 0 raises the interrupt pin.
module cas_channel_alarm #(
    parameter int unsigned SHORT_QUAL_CYCLES = 32'(cas_pkg::CAS_SHORT_QUAL_CYC),
    parameter int unsigned LONG_QUAL_CYCLES = 32'(cas_pkg::CAS_LONG_QUAL_CYC)
) (
    input wire logic MCLK_IN,
    input wire logic RST_N_IN,
    input wire logic [12:0] ADDRESS_IN,
    input wire logic READ_IN,
    input wire logic WRITE_IN,
    input wire logic [3:0] BYTEENABLE_IN,
    input wire logic [31:0] WRITEDATA_IN,
    output logic [31:0] READDATA_OUT,
    output logic WAITREQUEST_OUT,
    input wire cas_pkg::cas_alarm_t ALARM_IN,
    input wire cas_pkg::cas_error_t ERROR_EVT_IN,
    input wire logic AUTO_LOOPBACK_CONTROL_IN,
    input wire logic T1_MODE_IN,
    output logic IRQ_OUT
);

    // ------------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------------
    if (SHORT_QUAL_CYCLES < 1 || LONG_QUAL_CYCLES < 1) begin : g_bad_qual
        $error("qualifying cycle counts must be at least one");
    end
    if (SHORT_QUAL_CYCLES == 32'hffff_ffff || LONG_QUAL_CYCLES == 32'hffff_ffff) begin : g_bad_max
        $error("qualifying cycle counts must leave room in the counter");
    end

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    cas_pkg::cas_state_t state_q;
    cas_pkg::cas_state_t state_d;

    logic [7:0] new_a;
    logic [7:0] new_b;
    logic [7:0] ev_a;
    logic [7:0] ev_b;
    logic [7:0] ev_err;
    logic [7:0] clr_a;
    logic [7:0] clr_b;
    logic [7:0] clr_err;
    logic [7:0] rd_val;
    logic [7:0] wbyte;
    logic [31:0] act_limit;
    logic act_qual;
    logic deact_qual;
    logic req;
    logic mapped;
    logic wr_now;

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;

        // live levels sampled each cycle
        new_a = 8'h00;
        new_a[7] = ALARM_IN.auto_loopback_state;
        new_a[4] = ALARM_IN.driver_overcurrent_state;
        new_a[3] = ALARM_IN.tx_clock_missing_state;
        new_a[2] = ALARM_IN.tx_signal_loss_state;
        new_a[1] = ALARM_IN.sys_signal_loss_state;
        new_a[0] = ALARM_IN.line_signal_loss_state;

        // activate code qualification timer
        act_limit = AUTO_LOOPBACK_CONTROL_IN ? LONG_QUAL_CYCLES : SHORT_QUAL_CYCLES;
        act_qual = 1'b0;
        if (!ALARM_IN.inband_activate_detect) begin
            state_d.act_cnt = cas_pkg::CAS_ZERO32_RST;
        end else if (state_q.act_cnt >= act_limit) begin
            act_qual = 1'b1;
        end else begin
            state_d.act_cnt = state_q.act_cnt + 32'h0000_0001;
        end

        // deactivate code qualification, T1/J1 with auto loopback off only
        deact_qual = 1'b0;
        if (!ALARM_IN.inband_deactivate_detect || !T1_MODE_IN
                || AUTO_LOOPBACK_CONTROL_IN) begin
            state_d.deact_cnt = cas_pkg::CAS_ZERO32_RST;
        end else if (state_q.deact_cnt >= SHORT_QUAL_CYCLES) begin
            deact_qual = 1'b1;
        end else begin
            state_d.deact_cnt = state_q.deact_cnt + 32'h0000_0001;
        end

        new_b = 8'h00;
        new_b[7] = ALARM_IN.sys_alarm_indication_state;
        new_b[6] = ALARM_IN.line_alarm_indication_state;
        new_b[5] = ALARM_IN.pattern_sync_state;
        new_b[cas_pkg::CAS_B_ACTIVATE_POS] = act_qual;
        new_b[cas_pkg::CAS_B_DEACTIVATE_POS] = deact_qual;

        state_d.stat_a = new_a & cas_pkg::CAS_STAT_A_BITS;
        state_d.stat_b = new_b & cas_pkg::CAS_STAT_B_BITS;

        // transition events per bit
        ev_a = 8'h00;
        ev_b = 8'h00;
        for (int i = 0; i < 8; i++) begin
            ev_a[i] = state_q.edge_a[i] ? (state_d.stat_a[i] ^ state_q.stat_a[i])
                : (state_d.stat_a[i] & ~state_q.stat_a[i]);
            ev_b[i] = state_q.edge_b[i] ? (state_d.stat_b[i] ^ state_q.stat_b[i])
                : (state_d.stat_b[i] & ~state_q.stat_b[i]);
        end
        ev_err = {2'b00, ERROR_EVT_IN};

        // bus slave: one wait cycle, then a single acknowledge cycle
        req = READ_IN | WRITE_IN;
        mapped = (ADDRESS_IN[1:0] == 2'b00);
        rd_val = 8'h00;
        if (mapped) begin
            case (ADDRESS_IN[12:2])
                cas_pkg::CAS_IDX_ERROR_INTERRUPT_MASK: rd_val = state_q.err_mask;
                cas_pkg::CAS_IDX_ALARM_STATUS_A: rd_val = state_q.stat_a;
                cas_pkg::CAS_IDX_ALARM_STATUS_B: rd_val = state_q.stat_b;
                cas_pkg::CAS_IDX_STATUS_A_MASK: rd_val = state_q.mask_a;
                cas_pkg::CAS_IDX_STATUS_B_MASK: rd_val = state_q.mask_b;
                cas_pkg::CAS_IDX_STATUS_A_EDGE: rd_val = state_q.edge_a;
                cas_pkg::CAS_IDX_STATUS_B_EDGE: rd_val = state_q.edge_b;
                cas_pkg::CAS_IDX_STATUS_A_STICKY: rd_val = state_q.sticky_a;
                cas_pkg::CAS_IDX_STATUS_B_STICKY: rd_val = state_q.sticky_b;
                cas_pkg::CAS_IDX_ERROR_STICKY: rd_val = state_q.sticky_err;
                default: rd_val = 8'h00;
            endcase
        end

        wr_now = 1'b0;
        case (state_q.bus_st)
            cas_pkg::CAS_BUS_IDLE: begin
                if (req) begin
                    state_d.bus_st = cas_pkg::CAS_BUS_ACK;
                    state_d.waitreq = 1'b0;
                    if (READ_IN) begin
                        state_d.rdata = {24'h00_0000, rd_val};
                    end
                end
            end
            cas_pkg::CAS_BUS_ACK: begin
                state_d.bus_st = cas_pkg::CAS_BUS_IDLE;
                state_d.waitreq = 1'b1;
                wr_now = WRITE_IN & BYTEENABLE_IN[0] & mapped;
            end
            default: begin
                state_d.bus_st = cas_pkg::CAS_BUS_IDLE;
                state_d.waitreq = 1'b1;
            end
        endcase

        // register writes; status registers have no write path
        wbyte = WRITEDATA_IN[7:0];
        clr_a = 8'h00;
        clr_b = 8'h00;
        clr_err = 8'h00;
        if (wr_now) begin
            case (ADDRESS_IN[12:2])
                cas_pkg::CAS_IDX_ERROR_INTERRUPT_MASK:
                    state_d.err_mask = wbyte & cas_pkg::CAS_ERR_BITS;
                cas_pkg::CAS_IDX_STATUS_A_MASK:
                    state_d.mask_a = wbyte & cas_pkg::CAS_STAT_A_BITS;
                cas_pkg::CAS_IDX_STATUS_B_MASK:
                    state_d.mask_b = wbyte & cas_pkg::CAS_STAT_B_BITS;
                cas_pkg::CAS_IDX_STATUS_A_EDGE:
                    state_d.edge_a = wbyte & cas_pkg::CAS_STAT_A_BITS;
                cas_pkg::CAS_IDX_STATUS_B_EDGE:
                    state_d.edge_b = wbyte & cas_pkg::CAS_STAT_B_BITS;
                cas_pkg::CAS_IDX_STATUS_A_STICKY: clr_a = wbyte;
                cas_pkg::CAS_IDX_STATUS_B_STICKY: clr_b = wbyte;
                cas_pkg::CAS_IDX_ERROR_STICKY: clr_err = wbyte;
                default: clr_a = 8'h00;
            endcase
        end

        // sticky bits: a new event wins over a clear in the same cycle
        state_d.sticky_a = ((state_q.sticky_a & ~clr_a) | ev_a)
            & cas_pkg::CAS_STAT_A_BITS;
        state_d.sticky_b = ((state_q.sticky_b & ~clr_b) | ev_b)
            & cas_pkg::CAS_STAT_B_BITS;
        state_d.sticky_err = ((state_q.sticky_err & ~clr_err) | ev_err)
            & cas_pkg::CAS_ERR_BITS;

        // error mask bits 5..0 line up with the error event bits
        state_d.irq = |(state_d.sticky_err[5:3] & ~state_d.err_mask[5:3])
            | |(state_d.sticky_err[2:0] & ~state_d.err_mask[2:0])
            | |(state_d.sticky_a & ~state_d.mask_a)
            | |(state_d.sticky_b & ~state_d.mask_b);
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state_q.bus_st <= cas_pkg::CAS_BUS_IDLE;
            state_q.waitreq <= 1'b1;
            state_q.rdata <= cas_pkg::CAS_ZERO32_RST;
            state_q.irq <= 1'b0;
            state_q.err_mask <= cas_pkg::CAS_ERR_MASK_RST;
            state_q.mask_a <= cas_pkg::CAS_STAT_A_MASK_RST;
            state_q.mask_b <= cas_pkg::CAS_STAT_B_MASK_RST;
            state_q.edge_a <= cas_pkg::CAS_ZERO8_RST;
            state_q.edge_b <= cas_pkg::CAS_ZERO8_RST;
            state_q.sticky_a <= cas_pkg::CAS_ZERO8_RST;
            state_q.sticky_b <= cas_pkg::CAS_ZERO8_RST;
            state_q.sticky_err <= cas_pkg::CAS_ZERO8_RST;
            state_q.stat_a <= cas_pkg::CAS_ZERO8_RST;
            state_q.stat_b <= cas_pkg::CAS_ZERO8_RST;
            state_q.act_cnt <= cas_pkg::CAS_ZERO32_RST;
            state_q.deact_cnt <= cas_pkg::CAS_ZERO32_RST;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign READDATA_OUT = state_q.rdata;
    assign WAITREQUEST_OUT = state_q.waitreq;
    assign IRQ_OUT = state_q.irq;

endmodule // cas_channel_alarm

/* tb/cas_channel_alarm_chk.sv */
// checker: bus handshake, status mapping and interrupt timing of the channel alarm block
`timescale 1ns/1ps
module cas_channel_alarm_chk #(
    parameter int unsigned SHORT_QUAL_CYCLES = 20,
    parameter int unsigned LONG_QUAL_CYCLES = 50
) (
    input wire logic MCLK_IN,
    input wire logic RST_N_IN,
    input wire logic [12:0] ADDRESS_IN,
    input wire logic READ_IN,
    input wire logic WRITE_IN,
    input wire logic [3:0] BYTEENABLE_IN,
    input wire logic [31:0] WRITEDATA_IN,
    input wire logic [31:0] READDATA_OUT,
    input wire logic WAITREQUEST_OUT,
    input wire cas_pkg::cas_alarm_t ALARM_IN,
    input wire cas_pkg::cas_error_t ERROR_EVT_IN,
    input wire logic AUTO_LOOPBACK_CONTROL_IN,
    input wire logic T1_MODE_IN,
    input wire logic IRQ_OUT
);
    logic ack;
    logic rd_a;
    logic rd_b;
    logic acc_m;
    logic [10:0] p1_q;
    logic [10:0] p2_q;
    logic [5:0] mask_q;
    assign ack = !WAITREQUEST_OUT;
    assign rd_a = ack && READ_IN && ADDRESS_IN == {cas_pkg::CAS_IDX_ALARM_STATUS_A, 2'b00};
    assign rd_b = ack && READ_IN && ADDRESS_IN == {cas_pkg::CAS_IDX_ALARM_STATUS_B, 2'b00};
    assign acc_m = ack && ADDRESS_IN == {cas_pkg::CAS_IDX_ERROR_INTERRUPT_MASK, 2'b00};
    // ------------------------------------------------------------------
    // detector levels two edges back, shadow of the error mask
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            p1_q <= 11'h000;
            p2_q <= 11'h000;
            mask_q <= 6'h3f;
        end else begin
            p1_q <= ALARM_IN;
            p2_q <= p1_q;
            if (acc_m && WRITE_IN && BYTEENABLE_IN[0]) begin
                mask_q <= WRITEDATA_IN[5:0];
            end
        end
    end
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_ack_one_cycle: assert property ((READ_IN || WRITE_IN) && WAITREQUEST_OUT |=> ack)
        else $error("acknowledge late");
    a_ack_single: assert property (ack |=> !ack)
        else $error("acknowledge longer than one cycle");
    a_rdata_hold: assert property (!(READ_IN && WAITREQUEST_OUT) |=> $stable(READDATA_OUT))
        else $error("read data changed without a read");
    a_stat_a_map: assert property (rd_a |->
        READDATA_OUT == {24'h00_0000, p2_q[10], 2'b00, p2_q[9:5]})
        else $error("status a read wrong");
    a_stat_b_map: assert property (rd_b |->
        READDATA_OUT[31:2] == {24'h00_0000, p2_q[4:2], 3'b000})
        else $error("status b read wrong");
    a_act_drop: assert property (rd_b && !p2_q[1] |-> !READDATA_OUT[1])
        else $error("activate status without detect");
    a_deact_gate: assert property (
        rd_b && (AUTO_LOOPBACK_CONTROL_IN || !T1_MODE_IN || !p2_q[0]) |-> !READDATA_OUT[0])
        else $error("deactivate status not gated");
    a_mask_read: assert property (acc_m && READ_IN |->
        READDATA_OUT == {26'h000_0000, mask_q})
        else $error("error mask read wrong");
    a_err_irq: assert property (
        |(6'(ERROR_EVT_IN) & ~mask_q) |=> IRQ_OUT)
        else $error("unmasked error gave no interrupt");
    a_misalign_zero: assert property (
        ack && READ_IN && ADDRESS_IN[1:0] != 2'b00 |-> READDATA_OUT == 32'h0000_0000)
        else $error("misaligned read not zero");
    c_act_set: cover property (rd_b && READDATA_OUT[1]);
    c_irq_rise: cover property ($rose(IRQ_OUT));
    c_misalign: cover property (ack && ADDRESS_IN[1:0] != 2'b00);
endmodule // cas_channel_alarm_chk

/* tb/cas_channel_alarm_tb.sv */
// testbench: registers, status mapping, interrupt masks, edges and in-band qualification
`timescale 1ns/1ps
module cas_channel_alarm_tb;
    localparam logic [10:0] i_em = cas_pkg::CAS_IDX_ERROR_INTERRUPT_MASK;
    localparam logic [10:0] i_sa = cas_pkg::CAS_IDX_ALARM_STATUS_A;
    localparam logic [10:0] i_sb = cas_pkg::CAS_IDX_ALARM_STATUS_B;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [12:0] addr = 13'h0000;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [3:0] be = 4'h1;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic waitreq;
    cas_pkg::cas_alarm_t alarm = '0;
    cas_pkg::cas_error_t err_evt = '0;
    logic auto_lp = 1'b0;
    logic t1 = 1'b1;
    logic irq;
    int n_errors = 0;
    int n_compared = 0;
    int n_cycles = 0;
    int bitpos[9] = '{7, 4, 3, 2, 1, 0, 7, 6, 5};
    logic [31:0] q;
    always #2 clk = ~clk;
    cas_channel_alarm #(.SHORT_QUAL_CYCLES(20), .LONG_QUAL_CYCLES(50)) dut (
        .MCLK_IN(clk), .RST_N_IN(rst_n), .ADDRESS_IN(addr), .READ_IN(rd), .WRITE_IN(wr),
        .BYTEENABLE_IN(be), .WRITEDATA_IN(wdata), .READDATA_OUT(rdata),
        .WAITREQUEST_OUT(waitreq), .ALARM_IN(alarm), .ERROR_EVT_IN(err_evt),
        .AUTO_LOOPBACK_CONTROL_IN(auto_lp), .T1_MODE_IN(t1), .IRQ_OUT(irq));
    task automatic print_verdict;
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        n_cycles++;
        if (n_cycles == 20000) begin
            n_errors++;
            $display("unexpected at %0t: run timed out", $time);
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_irq(input logic exp);
        @(negedge clk);
        chk({31'h0000_0000, irq}, {31'h0000_0000, exp});
        @(posedge clk);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one bus transfer: raise after an edge, hold until a rising edge sees waitrequest low
    task automatic bus(input logic w, input logic [12:0] a, input logic [7:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= {24'h00_0000, d};
        do @(posedge clk); while (waitreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [10:0] idx, input logic [7:0] exp);
        bus(1'b0, {idx, 2'b00}, 8'h00);
        chk(q, {24'h00_0000, exp});
    endtask
    task automatic wr_reg(input logic [10:0] idx, input logic [7:0] d);
        bus(1'b1, {idx, 2'b00}, d);
    endtask
    task automatic pulse(input logic [5:0] e);
        err_evt <= cas_pkg::cas_error_t'(e);
        cyc(1);
        err_evt <= '0;
        cyc(2);
    endtask
    task automatic t_regs;
        rd_chk(i_em, 8'h3f);
        rd_chk(cas_pkg::CAS_IDX_STATUS_A_MASK, cas_pkg::CAS_STAT_A_MASK_RST);
        rd_chk(cas_pkg::CAS_IDX_STATUS_B_MASK, cas_pkg::CAS_STAT_B_MASK_RST);
        rd_chk(i_sb, 8'h00);
        wr_reg(i_em, 8'hff);
        rd_chk(i_em, 8'h3f);
        wr_reg(i_em, 8'h15);
        be <= 4'h0;
        wr_reg(i_em, 8'h3f);
        be <= 4'h1;
        rd_chk(i_em, 8'h15);
        wr_reg(i_em, 8'h3f);
        wr_reg(i_sa, 8'hff);
        wr_reg(i_sb, 8'hff);
        rd_chk(i_sa, 8'h00);
        rd_chk(i_sb, 8'h00);
        bus(1'b0, {i_em, 2'b10}, 8'h00);
        chk(q, 32'h0000_0000);
        rd_chk(11'h7f0, 8'h00);
        $display("test registers done");
    endtask
    task automatic t_status;
        for (int i = 0; i < 9; i++) begin
            alarm <= cas_pkg::cas_alarm_t'(11'h400 >> i);
            cyc(2);
            rd_chk((i < 6) ? i_sa : i_sb, 8'h01 << bitpos[i]);
        end
        alarm <= '0;
        $display("test status done");
    endtask
    task automatic t_errors;
        pulse(6'h3f);
        chk_irq(1'b0);
        for (int k = 0; k < 6; k++) begin
            wr_reg(cas_pkg::CAS_IDX_ERROR_STICKY, 8'h3f);
            wr_reg(i_em, 8'h3f ^ (8'h01 << k));
            pulse(6'h3f ^ (6'h01 << k));
            chk_irq(1'b0);
            pulse(6'h01 << k);
            chk_irq(1'b1);
            wr_reg(cas_pkg::CAS_IDX_ERROR_STICKY, 8'h00);
            chk_irq(1'b1);
            wr_reg(cas_pkg::CAS_IDX_ERROR_STICKY, 8'h01 << k);
            cyc(1);
            chk_irq(1'b0);
        end
        wr_reg(i_em, 8'h3f);
        $display("test error masks done");
    endtask
    task automatic t_edge;
        wr_reg(cas_pkg::CAS_IDX_STATUS_A_STICKY, 8'h9f);
        wr_reg(cas_pkg::CAS_IDX_STATUS_A_MASK, 8'h8f);
        chk_irq(1'b0);
        for (int e = 0; e < 2; e++) begin
            alarm <= cas_pkg::cas_alarm_t'(11'h200);
            cyc(3);
            chk_irq(1'b1);
            wr_reg(cas_pkg::CAS_IDX_STATUS_A_STICKY, 8'h10);
            alarm <= '0;
            cyc(3);
            chk_irq(e[0]);
            wr_reg(cas_pkg::CAS_IDX_STATUS_A_STICKY, 8'h10);
            wr_reg(cas_pkg::CAS_IDX_STATUS_A_EDGE, 8'h10);
        end
        wr_reg(cas_pkg::CAS_IDX_STATUS_A_MASK, 8'h9f);
        $display("test edge select done");
    endtask
    task automatic t_inband;
        alarm <= cas_pkg::cas_alarm_t'(11'h003);
        cyc(10);
        rd_chk(i_sb, 8'h00);
        cyc(20);
        rd_chk(i_sb, 8'h03);
        alarm <= '0;
        cyc(1);
        rd_chk(i_sb, 8'h00);
        auto_lp <= 1'b1;
        alarm <= cas_pkg::cas_alarm_t'(11'h003);
        cyc(35);
        rd_chk(i_sb, 8'h00);
        cyc(25);
        rd_chk(i_sb, 8'h02);
        alarm <= '0;
        cyc(1);
        auto_lp <= 1'b0;
        t1 <= 1'b0;
        alarm <= cas_pkg::cas_alarm_t'(11'h003);
        cyc(30);
        rd_chk(i_sb, 8'h02);
        t1 <= 1'b1;
        alarm <= '0;
        $display("test in-band done");
    endtask
    initial begin
        cyc(20);
        rst_n <= 1'b1;
        t_regs();
        t_status();
        t_errors();
        t_edge();
        t_inband();
        print_verdict();
    end
endmodule // cas_channel_alarm_tb

bind cas_channel_alarm cas_channel_alarm_chk #(
    .SHORT_QUAL_CYCLES(SHORT_QUAL_CYCLES), .LONG_QUAL_CYCLES(LONG_QUAL_CYCLES)) u_chk (
    .MCLK_IN(MCLK_IN), .RST_N_IN(RST_N_IN), .ADDRESS_IN(ADDRESS_IN), .READ_IN(READ_IN),
    .WRITE_IN(WRITE_IN), .BYTEENABLE_IN(BYTEENABLE_IN), .WRITEDATA_IN(WRITEDATA_IN),
    .READDATA_OUT(READDATA_OUT), .WAITREQUEST_OUT(WAITREQUEST_OUT), .ALARM_IN(ALARM_IN),
    .ERROR_EVT_IN(ERROR_EVT_IN), .AUTO_LOOPBACK_CONTROL_IN(AUTO_LOOPBACK_CONTROL_IN),
    .T1_MODE_IN(T1_MODE_IN), .IRQ_OUT(IRQ_OUT));
